//--- signal_mixer_defs.svh
// constants for the signal mixer: register indices, field positions, reset values
// assumes inclusion by bare name from the package and the design files
`ifndef SIGNAL_MIXER_DEFS_SVH
`define SIGNAL_MIXER_DEFS_SVH

// ----------------------------------------------------------------
// register addresses (4-bit register port)
// ----------------------------------------------------------------
`define ADDR_MOD_CONTROL   4'h0
`define ADDR_MOD_SOURCE    4'h1
`define ADDR_HIGH_CARRIER  4'h2
`define ADDR_LOW_CARRIER   4'h3

// ----------------------------------------------------------------
// modulation_control fields
// ----------------------------------------------------------------
`define CTL_ENABLE_BIT     7
`define CTL_PIN_OE_BIT     6
`define CTL_SLEW_BIT       5
`define CTL_INVERT_BIT     4
`define CTL_OUT_BIT        3
`define CTL_SWBIT_BIT      0
`define CTL_RESET          8'h20
`define CTL_WRITE_MASK     8'hf1

// ----------------------------------------------------------------
// source and carrier control fields
// ----------------------------------------------------------------
`define SRC_DETACH_BIT     7
`define SEL_LSB            0
`define SEL_MSB            3
`define CAR_INVERT_BIT     6
`define CAR_SYNC_BIT       5
`define SRC_WRITE_MASK     8'h8f
`define CAR_WRITE_MASK     8'hef
`define SRC_RESET          8'h00
`define CAR_RESET          8'h00

// ----------------------------------------------------------------
// select codes
// ----------------------------------------------------------------
`define MOD_SEL_SOFTWARE   4'h0
`define MOD_SEL_EXT_PIN    4'h1
`define MOD_SEL_PWM_FIRST  4'h2
`define MOD_SEL_CMP_FIRST  4'h6
`define MOD_SEL_SPI_FIRST  4'h8
`define MOD_SEL_UART       4'ha
`define CAR_SEL_GROUND     4'h0
`define CAR_SEL_EXT_A      4'h1
`define CAR_SEL_EXT_B      4'h2
`define CAR_SEL_REFCLK     4'h3
`define CAR_SEL_PWM_FIRST  4'h4

`endif

//--- signal_mixer_pkg.sv
// types shared by the signal mixer modules
// assumes the defs header sits in the same folder
package signal_mixer_pkg;
    `include "signal_mixer_defs.svh"

    // carrier switch-over states
    typedef enum logic [1:0] {
        ST_HIGH      = 2'b00,
        ST_WAIT_LOW  = 2'b01,
        ST_LOW       = 2'b10,
        ST_WAIT_HIGH = 2'b11
    } carrier_state_t;
endpackage

//--- carrier_path_if.sv
// bundle between top level and one carrier selector
// assumes one instance per carrier
`timescale 1ns/100ps
interface carrier_path_if;
    logic [3:0] sel;
    logic       invert;
    logic       detach;
    logic       carrier;
    logic       detach_pin;

    modport top (output sel, output invert, output detach, input carrier, input detach_pin);
    modport sel_side (input sel, input invert, input detach, output carrier, output detach_pin);
endinterface

//--- carrier_select.sv
// one carrier selector: source multiplexer, polarity, pin detach decode
// assumes the top has already forced sel to ground while disabled
`timescale 1ns/100ps
`include "signal_mixer_defs.svh"
module carrier_select
    import signal_mixer_pkg::*;
(
    // sources
    input  wire logic       ext_a_i,
    input  wire logic       ext_b_i,
    input  wire logic       refclk_i,
    input  wire logic [3:0] pwm_i,
    // control bundle
    carrier_path_if.sel_side cp
);
    // ----------------------------------------------------------------
    // source mux
    // ----------------------------------------------------------------
    logic raw;
    logic [3:0] pwm_idx;

    // reserved codes fall through to a constant low
    always_comb begin
        pwm_idx = cp.sel - `CAR_SEL_PWM_FIRST;
        case (cp.sel)
            `CAR_SEL_GROUND: raw = 1'b0;
            `CAR_SEL_EXT_A:  raw = ext_a_i;
            `CAR_SEL_EXT_B:  raw = ext_b_i;
            `CAR_SEL_REFCLK: raw = refclk_i;
            4'h4, 4'h5, 4'h6, 4'h7: raw = pwm_i[pwm_idx[1:0]];
            default:         raw = 1'b0;
        endcase
    end

    // polarity after the mux, so ground inverted reads as high
    assign cp.carrier = raw ^ cp.invert;

    // detach one-hot over the pwm outputs only; pins have no peripheral driver
    always_comb begin
        cp.detach_pin = 1'b0;
        if (cp.sel >= `CAR_SEL_PWM_FIRST && cp.sel <= 4'h7) begin
            cp.detach_pin = cp.detach;
        end
    end
endmodule

//--- signal_mixer.sv
// signal mixer top: registers, modulator select, carrier switch-over, output pin
// assumes all source inputs are synchronous to mclk_i
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "signal_mixer_defs.svh"

module signal_mixer
    import signal_mixer_pkg::*;
(
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    input  wire logic       clk_en_i,
    // register port
    input  wire logic [3:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // sources
    input  wire logic       external_modulator_pin_i,
    input  wire logic       external_carrier_pin_a_i,
    input  wire logic       external_carrier_pin_b_i,
    input  wire logic       refclk_i,
    input  wire logic [3:0] pwm_i,
    input  wire logic [1:0] comparator_i,
    input  wire logic [1:0] spi_sdo_i,
    input  wire logic       uart_tx_i,
    // pin side
    output logic            mixed_output_o,
    output logic            output_slew_limit_o,
    output logic      [3:0] pwm_pin_detach_o,
    output logic      [1:0] comparator_pin_detach_o,
    output logic      [1:0] spi_pin_detach_o,
    output logic            uart_pin_detach_o
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // one byte per register address
    // all next values except state_nxt come from one process
    logic [7:0] ctl_r, ctl_nxt;
    logic [7:0] src_r, src_nxt;
    logic [7:0] high_time_carrier_r, high_time_carrier_nxt;
    logic [7:0] low_time_carrier_r, low_time_carrier_nxt;
    // flopped so no mux glitch reaches
    // software or the pin
    logic [7:0] rdata_r, rdata_nxt;
    logic       out_r, out_nxt;
    logic       pin_r, pin_nxt;
    // carrier switch-over phase
    carrier_state_t state_r, state_nxt;

    // decoded enable and live mixing nets
    logic enable;
    logic mod_sig;
    logic mixed;
    logic high_carrier;
    logic low_carrier;

    // every override keys off this bit;
    // stored select codes stay untouched
    assign enable = ctl_r[`CTL_ENABLE_BIT];

    // ----------------------------------------------------------------
    // carrier selectors
    // ----------------------------------------------------------------
    // one bundle per carrier
    carrier_path_if high_cp ();
    carrier_path_if low_cp ();

    // disabled mixer forces both carrier selects to ground (invert still applies), registers keep their codes
    assign high_cp.sel    = enable ? high_time_carrier_r[`SEL_MSB:`SEL_LSB] : `CAR_SEL_GROUND;
    assign high_cp.invert = high_time_carrier_r[`CAR_INVERT_BIT];
    assign high_cp.detach = high_time_carrier_r[`SRC_DETACH_BIT];
    assign low_cp.sel     = enable ? low_time_carrier_r[`SEL_MSB:`SEL_LSB] : `CAR_SEL_GROUND;
    assign low_cp.invert  = low_time_carrier_r[`CAR_INVERT_BIT];
    assign low_cp.detach  = low_time_carrier_r[`SRC_DETACH_BIT];
    assign high_carrier   = high_cp.carrier;
    assign low_carrier    = low_cp.carrier;

    // both selectors share the source pins
    carrier_select u_high (
        .ext_a_i  (external_carrier_pin_a_i),
        .ext_b_i  (external_carrier_pin_b_i),
        .refclk_i (refclk_i),
        .pwm_i    (pwm_i),
        .cp       (high_cp)
    );

    carrier_select u_low (
        .ext_a_i  (external_carrier_pin_a_i),
        .ext_b_i  (external_carrier_pin_b_i),
        .refclk_i (refclk_i),
        .pwm_i    (pwm_i),
        .cp       (low_cp)
    );

    // ----------------------------------------------------------------
    // modulator select
    // ----------------------------------------------------------------
    // effective select after the override
    logic [3:0] mod_sel;
    logic [3:0] mod_off;

    // disabled: software bit, code kept
    assign mod_sel = enable ? src_r[`SEL_MSB:`SEL_LSB] : `MOD_SEL_SOFTWARE;

    // reserved codes read as constant low so
    // a stale select leaks no source
    always_comb begin
        mod_off = mod_sel - `MOD_SEL_PWM_FIRST;
        case (mod_sel)
            `MOD_SEL_SOFTWARE: mod_sig = ctl_r[`CTL_SWBIT_BIT];
            `MOD_SEL_EXT_PIN:  mod_sig = external_modulator_pin_i;
            4'h2, 4'h3, 4'h4, 4'h5: mod_sig = pwm_i[mod_off[1:0]];
            4'h6, 4'h7: mod_sig = comparator_i[mod_sel[0]];
            4'h8, 4'h9: mod_sig = spi_sdo_i[mod_sel[0]];
            `MOD_SEL_UART:     mod_sig = uart_tx_i;
            default:           mod_sig = 1'b0;
        endcase
    end

    // modulator detach decode, merged with carrier detaches on the pwm lines
    always_comb begin
        logic [3:0] pwm_det;
        pwm_det = 4'h0;
        comparator_pin_detach_o = 2'b00;
        spi_pin_detach_o = 2'b00;
        uart_pin_detach_o = 1'b0;
        // parked mixer detaches nothing
        if (src_r[`SRC_DETACH_BIT] && enable) begin
            case (mod_sel)
                4'h2, 4'h3, 4'h4, 4'h5: pwm_det[mod_off[1:0]] = 1'b1;
                4'h6, 4'h7: comparator_pin_detach_o[mod_sel[0]] = 1'b1;
                4'h8, 4'h9: spi_pin_detach_o[mod_sel[0]] = 1'b1;
                `MOD_SEL_UART: uart_pin_detach_o = 1'b1;
                default: pwm_det = 4'h0;
            endcase
        end
        // carrier and modulator requests merge
        if (high_cp.detach_pin) begin
            pwm_det[high_cp.sel[1:0]] = 1'b1;
        end
        if (low_cp.detach_pin) begin
            pwm_det[low_cp.sel[1:0]] = 1'b1;
        end
        pwm_pin_detach_o = pwm_det;
    end

    // ----------------------------------------------------------------
    // carrier switch-over
    // ----------------------------------------------------------------
    // without sync the carrier follows the modulator at once and pulses may be
    // cut short; with sync the running carrier is kept until it reads low
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_HIGH: begin
                if (!mod_sig) begin
                    if (high_time_carrier_r[`CAR_SYNC_BIT] && high_carrier) begin
                        state_nxt = ST_WAIT_LOW;
                    end else begin
                        state_nxt = ST_LOW;
                    end
                end
            end
            ST_WAIT_LOW: begin
                // modulator back: cancel switch
                if (mod_sig) begin
                    state_nxt = ST_HIGH;
                end else if (!high_carrier) begin
                    state_nxt = ST_LOW;
                end
            end
            ST_LOW: begin
                if (mod_sig) begin
                    if (low_time_carrier_r[`CAR_SYNC_BIT] && low_carrier) begin
                        state_nxt = ST_WAIT_HIGH;
                    end else begin
                        state_nxt = ST_HIGH;
                    end
                end
            end
            ST_WAIT_HIGH: begin
                // modulator back: cancel switch
                if (!mod_sig) begin
                    state_nxt = ST_LOW;
                end else if (!low_carrier) begin
                    state_nxt = ST_HIGH;
                end
            end
            // unreachable; back to low phase
            default: state_nxt = ST_LOW;
        endcase
    end

    // mixing is combinational on the selected sources, but reaches the pin
    // only through pin_r, which holds while clk_en_i is low; out_r only feeds the readback
    // carrier follows the next phase: no
    // cycle of lag without sync, and a wait
    // phase keeps the old carrier
    always_comb begin
        case (state_nxt)
            ST_HIGH, ST_WAIT_LOW: mixed = high_carrier & mod_sig;
            default:              mixed = low_carrier & mod_sig;
        endcase
        if (!enable) begin
            mixed = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // output pin and register next values
    // ----------------------------------------------------------------
    // writes, readback and output in one
    // process; read data hold until the
    // next read
    always_comb begin
        ctl_nxt   = ctl_r;
        src_nxt   = src_r;
        high_time_carrier_nxt  = high_time_carrier_r;
        low_time_carrier_nxt  = low_time_carrier_r;
        rdata_nxt = rdata_r;
        // invert applies even while disabled
        out_nxt   = mixed ^ ctl_r[`CTL_INVERT_BIT];
        // pin stays low while the pin output is gated off
        pin_nxt   = ctl_r[`CTL_PIN_OE_BIT] ? out_nxt : 1'b0;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `ADDR_MOD_CONTROL:  ctl_nxt  = reg_wdata_i & `CTL_WRITE_MASK;
                `ADDR_MOD_SOURCE:   src_nxt  = reg_wdata_i & `SRC_WRITE_MASK;
                `ADDR_HIGH_CARRIER: high_time_carrier_nxt = reg_wdata_i & `CAR_WRITE_MASK;
                `ADDR_LOW_CARRIER:  low_time_carrier_nxt = reg_wdata_i & `CAR_WRITE_MASK;
                default:            ctl_nxt  = ctl_r;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ADDR_MOD_CONTROL: begin
                    rdata_nxt = ctl_r;
                    rdata_nxt[`CTL_OUT_BIT] = out_r;
                end
                `ADDR_MOD_SOURCE:   rdata_nxt = src_r;
                `ADDR_HIGH_CARRIER: rdata_nxt = high_time_carrier_r;
                `ADDR_LOW_CARRIER:  rdata_nxt = low_time_carrier_r;
                default:            rdata_nxt = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    // clock enable low freezes every flop;
    // reset parks the mixer, slew limit on
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_r   <= `CTL_RESET;
            src_r   <= `SRC_RESET;
            high_time_carrier_r  <= `CAR_RESET;
            low_time_carrier_r  <= `CAR_RESET;
            rdata_r <= 8'h00;
            out_r   <= 1'b0;
            pin_r   <= 1'b0;
            state_r <= ST_LOW;
        end else if (clk_en_i) begin
            ctl_r   <= ctl_nxt;
            src_r   <= src_nxt;
            high_time_carrier_r  <= high_time_carrier_nxt;
            low_time_carrier_r  <= low_time_carrier_nxt;
            rdata_r <= rdata_nxt;
            out_r   <= out_nxt;
            pin_r   <= pin_nxt;
            state_r <= state_nxt;
        end
    end

    // outputs straight from flops
    assign reg_rdata_o         = rdata_r;
    assign mixed_output_o      = pin_r;
    assign output_slew_limit_o = ctl_r[`CTL_SLEW_BIT];
endmodule

//--- signal_mixer_props.sv
// checker for the signal mixer top ports
// assumes a bind from the bench top, one clock domain
`timescale 1ns/100ps
module signal_mixer_props
    import signal_mixer_pkg::*;
(
    // clock, reset, register port
    input wire logic       mclk_i,
    input wire logic       reset_n_i,
    input wire logic       clk_en_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // pin side
    input wire logic       mixed_output_o,
    input wire logic       output_slew_limit_o,
    input wire logic [3:0] pwm_pin_detach_o,
    input wire logic [1:0] comparator_pin_detach_o,
    input wire logic [1:0] spi_pin_detach_o,
    input wire logic       uart_pin_detach_o
);
    // ----------------------------------------------------------------
    // shadow registers: configuration seen from the port side
    // ----------------------------------------------------------------
    logic [7:0] ctl_r, src_r, hcar_r, ctl_nxt, src_nxt, hcar_nxt;
    logic       wr_en;
    assign wr_en = reg_wr_i && clk_en_i;
    // masks mirror the writable bits, so read-only bits never leak in
    always_comb begin
        ctl_nxt  = (wr_en && reg_addr_i == 4'h0) ? (reg_wdata_i & 8'hf1) : ctl_r;
        src_nxt  = (wr_en && reg_addr_i == 4'h1) ? (reg_wdata_i & 8'h8f) : src_r;
        hcar_nxt = (wr_en && reg_addr_i == 4'h2) ? (reg_wdata_i & 8'hef) : hcar_r;
    end
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_r  <= 8'h20;
            src_r  <= 8'h00;
            hcar_r <= 8'h00;
        end else begin
            ctl_r  <= ctl_nxt;
            src_r  <= src_nxt;
            hcar_r <= hcar_nxt;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_SLEW: assert property (wr_en && reg_addr_i == 4'h0
        |=> output_slew_limit_o == $past(reg_wdata_i[5])) else $error("slew bit mismatch");
    AST_RESET_DEFAULTS: assert property ($rose(reset_n_i)
        |-> output_slew_limit_o && !mixed_output_o && pwm_pin_detach_o == 4'h0)
        else $error("reset defaults wrong");
    AST_PIN_OFF: assert property ((!ctl_r[6] && $stable(ctl_r)) [*3]
        |-> !mixed_output_o) else $error("pin driven while output off");
    AST_DISABLED: assert property ((ctl_r[7:6] == 2'b01 && $stable(ctl_r)) [*3]
        |-> mixed_output_o == ctl_r[4]) else $error("disabled mixer drives data");
    AST_SW_MOD: assert property ((ctl_r[7:6] == 2'b11 && src_r[3:0] == 4'h0 && !ctl_r[0]
        && $stable(ctl_r) && $stable(src_r)) [*3] |-> mixed_output_o == ctl_r[4])
        else $error("software modulator low not honoured");
    AST_RES_MOD: assert property ((ctl_r[7:6] == 2'b11 && src_r[3:0] > 4'ha
        && $stable(ctl_r) && $stable(src_r)) [*3] |-> mixed_output_o == ctl_r[4])
        else $error("reserved modulator not low");
    AST_GROUND_CAR: assert property ((ctl_r[7:6] == 2'b11 && src_r[3:0] == 4'h0 && ctl_r[0]
        && !hcar_r[6] && (hcar_r[3:0] == 4'h0 || hcar_r[3]) && $stable(ctl_r)
        && $stable(src_r) && $stable(hcar_r)) [*3] |-> mixed_output_o == ctl_r[4])
        else $error("ground carrier not low");
    AST_DETACH_CAR: assert property (ctl_r[7] && hcar_r[7] && hcar_r[3:2] == 2'b01
        |-> pwm_pin_detach_o[hcar_r[1:0]]) else $error("carrier pin not detached");
    AST_DETACH_MOD: assert property (!(ctl_r[7] && src_r[7])
        |-> {comparator_pin_detach_o, spi_pin_detach_o, uart_pin_detach_o} == 5'h00)
        else $error("modulator detach without request");
    AST_READ_CTL: assert property (clk_en_i && reg_rd_i && reg_addr_i == 4'h0
        |=> (reg_rdata_o & 8'hf7) == ($past(ctl_r) & 8'hf7)) else $error("control readback");
endmodule

//--- peripheral_sources.sv
// stand-in for the on-chip peripherals and pins feeding the mixer
// assumes the bench chooses every level; no far-side rule binds these sources
`timescale 1ns/100ps
module peripheral_sources (
    // packed levels from the bench
    input  wire logic [12:0] level_i,
    // source levels
    output logic             ext_mod_o,
    output logic             ext_a_o,
    output logic             ext_b_o,
    output logic             refclk_o,
    output logic       [3:0] pwm_o,
    output logic       [1:0] comparator_o,
    output logic       [1:0] spi_sdo_o,
    output logic             uart_tx_o
);
    // fixed packing, bit 0 external modulator up to bit 12 uart
    assign {uart_tx_o, spi_sdo_o, comparator_o, pwm_o, refclk_o, ext_b_o, ext_a_o,
            ext_mod_o} = level_i;
endmodule

//--- signal_mixer_bench.sv
// self-checking bench: register map, detach decode, random mixing
// assumes design, package, source model and checker compile first
`timescale 1ns/100ps
module signal_mixer_bench;
    import signal_mixer_pkg::*;
    // ----------------------------------------------------------------
    // signals and scoreboard
    // ----------------------------------------------------------------
    typedef struct {int due; int kind; logic [8:0] val;} note_t;
    logic        mclk_i, reset_n_i, wr, rd, mixed, slew, uart_det;
    logic [3:0]  addr, pwm_det;
    logic [7:0]  wdata, rdata;
    logic [1:0]  cmp_det, spi_det;
    logic [12:0] lvl;
    wire  [12:0] s;
    logic [31:0] rng;
    int          cyc, error_cnt, compares;
    note_t       q[$];
    signal_mixer signal_mixer_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .external_modulator_pin_i(s[0]), .external_carrier_pin_a_i(s[1]),
        .external_carrier_pin_b_i(s[2]), .refclk_i(s[3]), .pwm_i(s[7:4]),
        .comparator_i(s[9:8]), .spi_sdo_i(s[11:10]), .uart_tx_i(s[12]),
        .mixed_output_o(mixed), .output_slew_limit_o(slew), .pwm_pin_detach_o(pwm_det),
        .comparator_pin_detach_o(cmp_det), .spi_pin_detach_o(spi_det),
        .uart_pin_detach_o(uart_det));
    peripheral_sources peripheral_sources_inst (.level_i(lvl), .ext_mod_o(s[0]),
        .ext_a_o(s[1]), .ext_b_o(s[2]), .refclk_o(s[3]), .pwm_o(s[7:4]),
        .comparator_o(s[9:8]), .spi_sdo_o(s[11:10]), .uart_tx_o(s[12]));
    // ----------------------------------------------------------------
    // expectation helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    // modulator codes 2 to 10 map onto source bits k+2 of the packing
    function automatic logic mod_of(input logic [3:0] k, input logic sw, input logic [12:0] v);
        if (k == 4'h0) return sw;
        if (k == 4'h1) return v[0];
        if (k <= 4'ha) return v[k + 4'h2];
        return 1'b0;
    endfunction
    function automatic logic car_of(input logic [3:0] k, input logic [12:0] v);
        return (k != 4'h0 && k <= 4'h7) ? v[k] : 1'b0;
    endfunction
    // sync bits stay clear wherever this model is used
    function automatic logic exp_pin(input logic [7:0] c, m, h, l, input logic [12:0] v);
        logic md;
        logic cr;
        md = c[7] ? mod_of(m[3:0], c[0], v) : c[0];
        cr = md ? (car_of(h[3:0], v) ^ h[6]) : (car_of(l[3:0], v) ^ l[6]);
        return c[6] & (c[7] ? ((cr & md) ^ c[4]) : c[4]);
    endfunction
    function automatic logic [8:0] det_of(input logic [3:0] m, h, l);
        logic [8:0] d;
        d = (m >= 4'h2 && m <= 4'ha) ? (9'h001 << (m - 4'h2)) : 9'h000;
        if (h[3:2] == 2'b01) d[h[1:0]] = 1'b1;
        if (l[3:2] == 2'b01) d[l[1:0]] = 1'b1;
        return d;
    endfunction
    // ----------------------------------------------------------------
    // driver tasks: notes fall due on the falling edge after the first edge that follows the driving edge
    // ----------------------------------------------------------------
    task automatic put(input int k, input logic [8:0] v);
        q.push_back('{cyc + 2, k, v});
    endtask
    task automatic bus(input logic w, r, input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00);
        put(1, {1'b0, e});
    endtask
    task automatic close_out();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // clock, monitor, watchdog
    // ----------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) cyc <= cyc + 1;
    // kinds: 0 pin, 1 read data, 2 detach vector, 3 slew
    always @(negedge mclk_i) begin
        note_t      n;
        logic [8:0] got;
        while (q.size() > 0 && q[0].due <= cyc) begin
            n = q.pop_front();
            compares++;
            got = (n.kind == 0) ? {8'h00, mixed} : (n.kind == 1) ? {1'b0, rdata} :
                  (n.kind == 2) ? {uart_det, spi_det, cmp_det, pwm_det} : {8'h00, slew};
            if (got !== n.val) begin
                error_cnt++;
                $display("BAD %0t kind %0d got %h want %h", $time, n.kind, got, n.val);
            end
        end
    end
    initial begin
        #50000;
        error_cnt++;
        close_out();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [7:0]  c, m, h, l;
        reset_n_i = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        lvl = 13'h0000;
        cyc = 0;
        error_cnt = 0;
        compares = 0;
        rng = 32'h0000ca76;
        repeat (4) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rd_chk(4'h0, 8'h20);
        rd_chk(4'h1, 8'h00);
        rd_chk(4'h2, 8'h00);
        rd_chk(4'h5, 8'h00);
        put(3, 9'h001);
        // all ones everywhere; reserved selects leave only the output invert
        for (int a = 1; a < 6; a++) bus(1'b1, 1'b0, (a == 4) ? 4'h0 : a[3:0], 8'hff);
        rd_chk(4'h1, 8'h8f);
        rd_chk(4'h2, 8'hef);
        rd_chk(4'h3, 8'hef);
        rd_chk(4'h5, 8'h00);
        rd_chk(4'h0, 8'hf9);
        put(0, 9'h001);
        bus(1'b1, 1'b0, 4'h0, 8'h80);
        for (int k = 0; k < 16; k++) begin
            bus(1'b1, 1'b0, 4'h1, {4'h8, k[3:0]});
            bus(1'b1, 1'b0, 4'h2, {4'h8, k[3:0] ^ 4'h3});
            bus(1'b1, 1'b0, 4'h3, {4'h8, k[3:0] + 4'h2});
            put(2, det_of(k[3:0], k[3:0] ^ 4'h3, k[3:0] + 4'h2));
        end
        // random mixing, every modulator and high carrier code twice; modulator codes 3, 7, 11, 15 and high codes 0, 4, 8, 12 run disabled
        for (int i = 0; i < 32; i++) begin
            r = xs();
            m = {r[7], 3'b000, i[3:0]};
            h = {r[15:14], 2'b00, ~i[3:0]};
            l = {r[23:22], 2'b00, r[27:24]};
            c = r[31:24] & 8'hf1;
            c[7] = (i % 4 != 3);
            bus(1'b1, 1'b0, 4'h1, m);
            bus(1'b1, 1'b0, 4'h2, h);
            bus(1'b1, 1'b0, 4'h3, l);
            bus(1'b1, 1'b0, 4'h0, c);
            repeat (10) begin
                bus(1'b0, 1'b0, 4'h0, 8'h00);
                r = xs();
                lvl <= r[12:0];
                put(0, {8'h00, exp_pin(c, m, h, l, r[12:0])});
                put(3, {8'h00, c[5]});
                put(2, det_of(c[7] & m[7] ? m[3:0] : 4'h0, c[7] & h[7] ? h[3:0] : 4'h0,
                    c[7] & l[7] ? l[3:0] : 4'h0));
            end
            rd_chk(4'h1, m);
        end
        // low carrier sync: a rising modulator keeps the low carrier until it falls
        bus(1'b1, 1'b0, 4'h1, 8'h01);
        bus(1'b1, 1'b0, 4'h2, 8'h02);
        bus(1'b1, 1'b0, 4'h3, 8'h21);
        bus(1'b1, 1'b0, 4'h0, 8'hc0);
        for (int j = 0; j < 5; j++) begin
            bus(1'b0, 1'b0, 4'h0, 8'h00);
            lvl <= (j == 0) ? 13'h0002 : (j < 3) ? 13'h0003 : (j == 3) ? 13'h0001 : 13'h0005;
            put(0, {8'h00, j == 1 || j == 2 || j == 4});
        end
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        for (int t = 0; t < 8 && q.size() > 0; t++) @(posedge mclk_i);
        if (q.size() > 0) error_cnt++;
        close_out();
    end
endmodule
bind signal_mixer signal_mixer_props signal_mixer_props_inst (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .mixed_output_o(mixed_output_o),
    .output_slew_limit_o(output_slew_limit_o), .pwm_pin_detach_o(pwm_pin_detach_o),
    .comparator_pin_detach_o(comparator_pin_detach_o), .spi_pin_detach_o(spi_pin_detach_o),
    .uart_pin_detach_o(uart_pin_detach_o));
